/* common/gtmr_pkg.sv */
// Package of constants shared by the general timer block
`default_nettype none

package gtmr_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_TMR = 5;
    localparam int AW = 5;
    localparam int DW = 16;

    // ------------------------------------------------------------
    // Register map: timer i sits at word i*4, status and mask above
    // ------------------------------------------------------------
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_COUNT = 2'h1;
    localparam logic [1:0] REG_PERIOD = 2'h2;
    localparam logic [4:0] ADDR_STATUS = 5'h14;
    localparam logic [4:0] ADDR_MASK = 5'h15;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int BIT_RUN = 15;
    localparam int BIT_STOP_IDLE = 13;
    localparam int BIT_GATE = 6;
    localparam int BIT_PS = 4;
    localparam int BIT_CHAIN = 3;
    localparam int BIT_SYNC = 2;
    localparam int BIT_CLK_SRC = 1;

    localparam logic [15:0] MASK_BASE_CTRL = 16'ha076;
    localparam logic [15:0] MASK_LOW_CTRL = 16'ha07a;
    localparam logic [15:0] MASK_HIGH_CTRL = 16'ha072;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] RST_PERIOD = 16'hffff;
    localparam logic [4:0] RST_STATUS = 5'h00;
    localparam logic [4:0] RST_MASK = 5'h00;

    // ------------------------------------------------------------
    // Prescaler terminal counts (ratio minus one)
    // ------------------------------------------------------------
    localparam logic [7:0] PS_LIM_1 = 8'h00;
    localparam logic [7:0] PS_LIM_8 = 8'h07;
    localparam logic [7:0] PS_LIM_64 = 8'h3f;
    localparam logic [7:0] PS_LIM_256 = 8'hff;

    localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;

endpackage

`default_nettype wire

/* common/gtmr_slice_if.sv */
// Interface between the timer register logic and one tick generator
`default_nettype none

interface gtmr_slice_if;
    logic run;
    logic ext_sel;
    logic gate_en;
    logic [1:0] ps;
    logic sync_sel;
    logic halt;
    logic tick;

    modport unit (
        input run,
        input ext_sel,
        input gate_en,
        input ps,
        input sync_sel,
        input halt,
        output tick
    );

    modport ctl (
        output run,
        output ext_sel,
        output gate_en,
        output ps,
        output sync_sel,
        output halt,
        input tick
    );
endinterface

`default_nettype wire

/* src/gtmr_slice.sv */
// Tick generator: pin synchroniser, clock select, gate and prescaler
`default_nettype none

module gtmr_slice (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic count_pin,
    gtmr_slice_if.unit ctl
);

    // ------------------------------------------------------------
    // Pin synchroniser and debounced level
    // ------------------------------------------------------------
    logic [2:0] sync_q;
    logic lvl_q;
    logic lvl_d;
    logic pin_edge;

    assign lvl_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : lvl_q;
    assign pin_edge = lvl_d & ~lvl_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_q <= 3'h0;
            lvl_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], count_pin};
            lvl_q <= lvl_d;
        end
    end

    // ------------------------------------------------------------
    // Source select and prescaler
    // ------------------------------------------------------------
    logic src_tick;
    logic active;
    logic [7:0] lim;
    logic [7:0] pre_q;
    logic [7:0] pre_d;
    logic raw_tick;
    logic raw_tick_q;

    // Gate only applies to the internal clock
    assign src_tick = ctl.ext_sel ? pin_edge
                    : (ctl.gate_en ? lvl_q : 1'b1); // R3 R4
    assign active = ctl.run & ~ctl.halt; // R5

    assign lim = (ctl.ps == 2'h3) ? gtmr_pkg::PS_LIM_256
               : (ctl.ps == 2'h2) ? gtmr_pkg::PS_LIM_64
               : (ctl.ps == 2'h1) ? gtmr_pkg::PS_LIM_8
               : gtmr_pkg::PS_LIM_1; // R1

    assign raw_tick = active & src_tick & (pre_q == lim); // R1
    assign pre_d = !active ? 8'h00
                 : !src_tick ? pre_q
                 : (pre_q == lim) ? 8'h00
                 : pre_q + 8'h01;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_q <= 8'h00;
            raw_tick_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            raw_tick_q <= raw_tick;
        end
    end

    // Synchronised external counting re-times the tick after the prescaler
    assign ctl.tick = (ctl.ext_sel & ctl.sync_sel) ? raw_tick_q
                    : raw_tick; // R2

endmodule

`default_nettype wire

/* src/gtmr_top.sv */
// General timers: one base timer and two chainable 16-bit timer pairs
`default_nettype none

// Notes on behaviour
// (R1) Prescale codes give 1:1, 1:8, 1:64, 1:256
// (R2) Sync bit matters only with external clock
// (R3) Gate enable works only on internal clock
// (R4) Clock source picks pin edges or peripheral clock
// (R5) Stop-in-idle halts the timer during idle
// (R6) Each pair is one 32-bit or two 16-bit
// (R7) Pairing bit in low control joins pair
// (R8) Separate pair timers never count asynchronously
// (R9) Chained pair is synchronous 32-bit timer/counter
// (R10) Chained pair interrupts on 32-bit period match
// (R11) Only first pair feeds the capture/compare time base
// (R12) All four pair timers run alone with features
// (R13) Event trigger comes only from first pair
// (R14) Low timer holds low word, high timer high
// (R15) High control ignored while pair is chained
// (R16) Chained pair uses low timer clock and gate
// (R17) Chained interrupt uses the high timer flag
// (R18) Count on tick, clear and flag on match

module gtmr_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic idle_mode,
    input wire logic base_timer_count_pin,
    input wire logic [3:0] pair_timer_count_pin,
    output logic irq,
    output logic evt_trig,
    output logic [15:0] tb_low,
    output logic [15:0] tb_high
);

    // ------------------------------------------------------------
    // Shared per-timer wires
    // ------------------------------------------------------------
    logic [15:0] ctl_w [gtmr_pkg::NUM_TMR];
    logic [15:0] cnt_w [gtmr_pkg::NUM_TMR];
    logic [15:0] per_w [gtmr_pkg::NUM_TMR];
    logic [gtmr_pkg::NUM_TMR-1:0] tick_w;
    logic [gtmr_pkg::NUM_TMR-1:0] m16_w;
    logic [gtmr_pkg::NUM_TMR-1:0] chain_w;
    logic [gtmr_pkg::NUM_TMR-1:0] flag_w;
    logic [gtmr_pkg::NUM_TMR-1:0] pin_w;

    logic [2:0] sel_tmr;
    logic [1:0] sel_reg;
    logic tmr_space;

    assign pin_w = {pair_timer_count_pin, base_timer_count_pin};
    assign sel_tmr = reg_addr[4:2];
    assign sel_reg = reg_addr[1:0];
    assign tmr_space = (reg_addr[4:2] < 3'h5);

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    genvar gi;
    for (gi = 0; gi < gtmr_pkg::NUM_TMR; gi++) begin : g_tmr
        localparam bit IS_LO = (gi == 1) || (gi == 3);
        localparam bit IS_HI = (gi == 2) || (gi == 4);
        localparam logic [15:0] WMASK = (gi == 0)
            ? gtmr_pkg::MASK_BASE_CTRL
            : (IS_LO ? gtmr_pkg::MASK_LOW_CTRL
                     : gtmr_pkg::MASK_HIGH_CTRL);
        localparam logic [2:0] MY_IDX = 3'(gi);

        logic [15:0] ctl_q;
        logic [15:0] cnt_q;
        logic [15:0] cnt_d;
        logic [15:0] per_q;
        logic adv;
        logic clr;
        logic hit;
        logic wsel;

        gtmr_slice_if sif ();

        gtmr_slice u_slice (
            .clk(clk),
            .rst_n(rst_n),
            .count_pin(pin_w[gi]),
            .ctl(sif.unit)
        );

        assign sif.run = ctl_q[gtmr_pkg::BIT_RUN];
        assign sif.ext_sel = ctl_q[gtmr_pkg::BIT_CLK_SRC]; // R4
        assign sif.gate_en = ctl_q[gtmr_pkg::BIT_GATE]; // R3 R12
        assign sif.ps = ctl_q[gtmr_pkg::BIT_PS +: 2]; // R1 R12
        // Pair timers always count in step with the clock
        assign sif.sync_sel = (gi == 0)
            ? ctl_q[gtmr_pkg::BIT_SYNC] : 1'b1; // R2 R8
        assign sif.halt = idle_mode
            & ctl_q[gtmr_pkg::BIT_STOP_IDLE]; // R5 R12

        assign tick_w[gi] = sif.tick;
        assign m16_w[gi] = (cnt_q == per_q);
        assign ctl_w[gi] = ctl_q;
        assign cnt_w[gi] = cnt_q;
        assign per_w[gi] = per_q;

        if (IS_LO) begin : g_lo
            assign chain_w[gi] = ctl_q[gtmr_pkg::BIT_CHAIN]; // R6 R7
            assign adv = tick_w[gi];
            assign hit = chain_w[gi]
                ? (m16_w[gi] & m16_w[gi+1]) : m16_w[gi]; // R10
            assign clr = adv & hit; // R18
            // Chained match is flagged by the high timer
            assign flag_w[gi] = clr & ~chain_w[gi]; // R17
        end else if (IS_HI) begin : g_hi
            logic src;
            assign chain_w[gi] = chain_w[gi-1]; // R7
            // Chained: low timer tick drives both halves
            assign src = chain_w[gi] ? tick_w[gi-1]
                                     : tick_w[gi]; // R15 R16
            assign adv = chain_w[gi]
                ? (tick_w[gi-1]
                   & (cnt_w[gi-1] == gtmr_pkg::COUNT_ALL_ONES))
                : tick_w[gi]; // R9 R14
            assign hit = chain_w[gi]
                ? (m16_w[gi-1] & m16_w[gi]) : m16_w[gi]; // R10
            assign clr = src & hit; // R18
            assign flag_w[gi] = clr; // R10 R17
        end else begin : g_base
            assign chain_w[gi] = 1'b0;
            assign adv = tick_w[gi];
            assign hit = m16_w[gi];
            assign clr = adv & hit; // R18
            assign flag_w[gi] = clr; // R18
        end

        assign wsel = reg_wr & (sel_tmr == MY_IDX);
        // Software write wins over counting in the same cycle
        assign cnt_d = (wsel & (sel_reg == gtmr_pkg::REG_COUNT))
                     ? reg_wdata
                     : clr ? 16'h0000
                     : adv ? cnt_q + 16'h0001
                     : cnt_q; // R18

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                ctl_q <= gtmr_pkg::RST_CTRL;
                cnt_q <= gtmr_pkg::RST_COUNT;
                per_q <= gtmr_pkg::RST_PERIOD;
            end else begin
                if (wsel & (sel_reg == gtmr_pkg::REG_CTRL)) begin
                    ctl_q <= reg_wdata & WMASK;
                end
                if (wsel & (sel_reg == gtmr_pkg::REG_PERIOD)) begin
                    per_q <= reg_wdata;
                end
                cnt_q <= cnt_d;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    logic [4:0] status_q;
    logic [4:0] status_d;
    logic [4:0] mask_q;
    logic [4:0] mask_d;
    logic [4:0] st_clr;
    logic irq_q;
    logic wr_status;
    logic wr_mask;

    assign wr_status = reg_wr & (reg_addr == gtmr_pkg::ADDR_STATUS);
    assign wr_mask = reg_wr & (reg_addr == gtmr_pkg::ADDR_MASK);
    assign st_clr = wr_status ? reg_wdata[4:0] : 5'h00;
    // New mask reaches irq at its own write edge, like a status clear
    assign mask_d = wr_mask ? reg_wdata[4:0] : mask_q;
    // A new event in the clearing cycle keeps its bit set
    assign status_d = (status_q & ~st_clr) | flag_w; // R17 R18

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_q <= gtmr_pkg::RST_STATUS;
            mask_q <= gtmr_pkg::RST_MASK;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= |(status_d & mask_d);
        end
    end

    // ------------------------------------------------------------
    // Event trigger and time base from the first pair
    // ------------------------------------------------------------
    logic evt_q;
    logic evt_d;

    assign evt_d = chain_w[1] ? flag_w[2] : flag_w[1]; // R13

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            evt_q <= 1'b0;
        end else begin
            evt_q <= evt_d;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [15:0] rd_mux;
    logic [15:0] rd_tmr;
    logic [15:0] rdata_q;
    logic [2:0] ridx;

    assign ridx = tmr_space ? sel_tmr : 3'h0;
    assign rd_tmr = (sel_reg == gtmr_pkg::REG_CTRL) ? ctl_w[ridx]
                  : (sel_reg == gtmr_pkg::REG_COUNT) ? cnt_w[ridx]
                  : (sel_reg == gtmr_pkg::REG_PERIOD) ? per_w[ridx]
                  : 16'h0000;
    assign rd_mux = tmr_space ? rd_tmr
                  : (reg_addr == gtmr_pkg::ADDR_STATUS)
                    ? {11'h000, status_q}
                  : (reg_addr == gtmr_pkg::ADDR_MASK)
                    ? {11'h000, mask_q}
                  : 16'h0000;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq = irq_q;
    assign evt_trig = evt_q;
    assign tb_low = g_tmr[1].cnt_q; // R11 R14
    assign tb_high = g_tmr[2].cnt_q; // R11 R14

endmodule

`default_nettype wire

/* verif/gtmr_chk.sv */
// Port checker of the general timer block
`default_nettype none
module gtmr_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic idle_mode,
    input wire logic irq,
    input wire logic evt_trig,
    input wire logic [15:0] tb_low,
    input wire logic [15:0] tb_high
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Shadow of the first pair's low control bits
    // ------------------------------------------------------------
    logic run_q, chain_q, sidl_q;
    wire logic wr_ctl = reg_wr && reg_addr == 5'h04;
    wire logic off = !run_q && !reg_wr;
    wire logic hold = idle_mode && sidl_q && !reg_wr;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_q <= 1'b0;
            chain_q <= 1'b0;
            sidl_q <= 1'b0;
        end else if (wr_ctl) begin
            run_q <= reg_wdata[15];
            chain_q <= reg_wdata[3];
            sidl_q <= reg_wdata[13];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_held;
        hold ##1 hold;
    endsequence
    property p_rd; !$past(reg_rd) |-> reg_rdata == 16'h0; endproperty
    a_rd: assert property (p_rd) else $error("stray read data");
    property p_fall; $fell(irq) |-> $past(reg_wr); endproperty
    a_fall: assert property (p_fall) else $error("irq fell alone");
    property p_low;
        !$past(reg_wr) && $changed(tb_low)
            |-> tb_low == $past(tb_low) + 16'h1 || tb_low == 16'h0;
    endproperty
    a_low: assert property (p_low) else $error("low count jump");
    property p_high;
        !$past(reg_wr) && $changed(tb_high)
            |-> tb_high == $past(tb_high) + 16'h1 || tb_high == 16'h0;
    endproperty
    a_high: assert property (p_high) else $error("high count jump");
    property p_carry;
        chain_q && !$past(reg_wr) && $changed(tb_high) |-> tb_low == 16'h0;
    endproperty
    a_carry: assert property (p_carry) else $error("bad carry");
    property p_held; s_held |=> $stable(tb_low); endproperty
    a_held: assert property (p_held) else $error("ran in idle");
    property p_stop; off [*3] |=> $stable(tb_low); endproperty
    a_stop: assert property (p_stop) else $error("ran while off");
    property p_evt;
        evt_trig |-> tb_low == 16'h0 || $past(tb_low) == 16'h0;
    endproperty
    a_evt: assert property (p_evt) else $error("event off match");
endmodule

bind gtmr_top gtmr_chk i_chk (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_mode(idle_mode),
    .irq(irq), .evt_trig(evt_trig), .tb_low(tb_low), .tb_high(tb_high));
`default_nettype wire

/* verif/gtmr_pins.sv */
// Model of the outside world driving the count pins
`default_nettype none
module gtmr_pins (
    input wire logic clk,
    output var logic [4:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Pin 0 feeds the base timer, pins 1 to 4 the pair timers
    // ------------------------------------------------------------
    initial pins = 5'h00;
    task automatic pulse(input int k, input int cnt, input int h);
        for (int i = 0; i < cnt; i++) begin
            repeat (h) @(posedge clk);
            pins[k] <= 1'b1;
            repeat (h) @(posedge clk);
            pins[k] <= 1'b0;
        end
    endtask
    task automatic level(input int k, input logic b);
        @(posedge clk);
        pins[k] <= b;
    endtask
endmodule
`default_nettype wire

/* verif/gtmr_tb_top.sv */
// Self-checking testbench of the general timer block
`default_nettype none
module gtmr_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, reg_wr, reg_rd, idle_mode, irq, evt_trig;
    logic [4:0] reg_addr, pins;
    logic [15:0] reg_wdata, reg_rdata, tb_low, tb_high, v;
    int fail_count, check_count, n;
    logic [15:0] rt [4] = '{16'h1, 16'h8, 16'h40, 16'h100};
    logic [15:0] msk [3] = '{16'ha076, 16'ha07a, 16'ha072};
    gtmr_top i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .idle_mode(idle_mode),
        .base_timer_count_pin(pins[0]), .pair_timer_count_pin(pins[4:1]),
        .irq(irq), .evt_trig(evt_trig), .tb_low(tb_low), .tb_high(tb_high));
    gtmr_pins i_pins (.clk(clk), .pins(pins));
    // ------------------------------------------------------------
    // Bus cycles and checks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic t_regs();
        rd(5'h06, 16'hffff);
        rd(5'h17, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            wr(5'(i * 4), 16'hffff);
            rd(5'(i * 4), msk[i]);
            wr(5'(i * 4), 16'h0000);
        end
    endtask
    task automatic t_ps();
        for (int p = 0; p < 4; p++) begin
            wr(5'h04, 16'h8000 | 16'(p << 4));
            repeat (3) begin
                v = tb_low;
                for (n = 0; n < 600 && tb_low === v; n++) step(1);
            end
            chk(16'(n), rt[p]);
        end
        wr(5'h04, 16'h0000);
    endtask
    task automatic t_chain();
        wr(5'h14, 16'h001f);
        wr(5'h06, 16'h0002);
        wr(5'h0a, 16'h0001);
        wr(5'h05, 16'hfff0);
        wr(5'h09, 16'h0000);
        wr(5'h08, 16'h0030);
        wr(5'h04, 16'h8008);
        for (n = 0; n < 100 && tb_high !== 16'h1; n++) step(1);
        chk(tb_high, 16'h0001);
        for (n = 0; n < 20 && tb_high !== 16'h0; n++) step(1);
        chk(tb_low, 16'h0000);
        wr(5'h04, 16'h0000);
        rd(5'h14, 16'h0004);
        wr(5'h14, 16'h001f);
    endtask
    task automatic t_irq();
        wr(5'h15, 16'h0002);
        wr(5'h06, 16'h0003);
        wr(5'h04, 16'h8000);
        for (n = 0; n < 50 && irq !== 1'b1; n++) step(1);
        chk({15'h0, irq}, 16'h0001);
        chk({15'h0, evt_trig}, 16'h0001);
        step(1);
        chk({15'h0, evt_trig}, 16'h0000);
        wr(5'h04, 16'h0000);
        rd(5'h14, 16'h0002);
        wr(5'h15, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
        wr(5'h15, 16'h0002);
        chk({15'h0, irq}, 16'h0001);
        wr(5'h14, 16'h0002);
        chk({15'h0, irq}, 16'h0000);
    endtask
    task automatic t_pins();
        wr(5'h06, 16'hffff);
        wr(5'h05, 16'h0000);
        wr(5'h04, 16'h8040);
        step(20);
        chk(tb_low, 16'h0000);
        i_pins.level(1, 1'b1);
        step(10);
        i_pins.level(1, 1'b0);
        chk({15'h0, tb_low !== 16'h0}, 16'h0001);
        wr(5'h04, 16'h8042);
        wr(5'h05, 16'h0000);
        i_pins.pulse(1, 5, 3);
        step(8);
        chk(tb_low, 16'h0005);
        for (int s = 0; s < 2; s++) begin
            wr(5'h01, 16'h0000);
            wr(5'h00, 16'h8002 | 16'(s << 2));
            i_pins.pulse(0, 4, 3);
            step(8);
            rd(5'h01, 16'h0004);
        end
        for (int k = 0; k < 2; k++) begin
            wr(5'(12 + k * 4), 16'h8002);
            i_pins.pulse(3 + k, 2 + k, 3);
            step(8);
            rd(5'(13 + k * 4), 16'(2 + k));
        end
    endtask
    task automatic t_idle();
        wr(5'h04, 16'ha000);
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            idle_mode <= 1'b1;
            step(3);
            v = tb_low;
            step(20);
            chk({15'h0, tb_low === v}, 16'(1 - s));
            @(posedge clk);
            idle_mode <= 1'b0;
            wr(5'h04, 16'h8000);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        wrap_up();
    end
    initial begin
        {rst_n, reg_wr, reg_rd, idle_mode} = 4'h0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_ps();
        t_chain();
        t_irq();
        t_pins();
        t_idle();
        wrap_up();
    end
endmodule
`default_nettype wire
